// >>> rtl/flash_space_map_and_program_launch.sv
// Flash control register, space mapping and programming launch
//
// Behaviour
// [R1] Default: user array readable only through code reads, never written.
// [R2] Latch map bit set maps column latches into data space writes.
// [R3] Latch writes accepted for addresses 0000h to 7FFFh while mapped.
// [R4] Bits 6:0 pick byte in page; bits 14:7 pick the page.
// [R5] Latch map bit overrides external data select for data writes.
// [R6] Space field: 00 user, 01 extra row, 10 security byte, 11 reserved.
// [R7] Code reads return the selected flash space; the only read path.
// [R8] Launch key nibble sits in bits 7:4 and guards programming start.
// [R9] Key 5 then key A in next write starts programming of space.
// [R10] Bit 0 busy is high during programming, clears itself afterwards.
// [R11] Space select at bits 2:1, latch map select at bit 3.
// [R12] Wrong second key abandons sequence; fresh correct pair needed.
`include "flash_map_consts.svh"
module flash_space_map_and_program_launch #(
    parameter int PROGRAM_CYCLES = `PROGRAM_TIME_US * `CLOCK_MHZ
)(
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // Special function register bus
    input  wire logic [7:0]               sfrAddr,
    input  wire logic                     sfrWrite,
    input  wire logic [7:0]               sfrWrData,
    output logic      [7:0]               sfrRdData,
    // Processor data space write and external data select
    input  wire logic                     dataWrite,
    input  wire logic [15:0]              dataAddr,
    input  wire logic [7:0]               dataWrData,
    input  wire logic                     externalDataSelect,
    output logic                          externalWrite,
    // Processor code space read
    input  wire logic                     codeRead,
    input  wire logic [15:0]              codeAddr,
    output logic      [7:0]               codeRdData,
    output logic                          codeRdValid,
    // Flash array side
    output flash_map_pkg::latch_write_type latchWrite,
    output logic      [1:0]               arrayReadSpace,
    output logic      [15:0]              arrayReadAddr,
    output logic                          arrayRead,
    input  wire logic [7:0]               arrayRdData,
    output logic                          programFlashArray,
    output logic      [1:0]               programSpace
);
    import flash_map_pkg::*;

    // ------------------------------------------------------------
    // Control register and launch sequencer
    // ------------------------------------------------------------
    flash_control_type control;
    flash_control_type next_control;
    launch_state_type  state;
    launch_state_type  next_state;
    logic              next_programFlashArray;
    logic [1:0]        next_programSpace;
    logic              timerDone;
    logic              regWrite;
    logic [3:0]        keyIn;

    assign regWrite = sfrWrite && (sfrAddr == `FLASH_CONTROL_ADDR);
    assign keyIn    = sfrWrData[`KEY_MSB:`KEY_LSB];

    // Register writes store the fields; the key drives the sequencer.
    // Busy is not writable by software so a stray write cannot hide it.
    always_comb
    begin
        next_control           = control;
        next_state             = state;
        next_programFlashArray = 1'b0;
        next_programSpace      = programSpace;
        if (regWrite)
        begin
            next_control.launchKey      = keyIn;                  // [R8]
            next_control.latchMapSelect = sfrWrData[`LATCH_MAP_BIT]; // [R11]
            next_control.spaceSelect    =
                sfrWrData[`SPACE_MSB:`SPACE_LSB];                 // [R11]
        end
        unique case (state)
            IDLE_ST:
            begin
                if (regWrite && keyIn == `KEY_FIRST)
                    next_state = ARMED_ST;                        // [R9]
            end
            ARMED_ST:
            begin
                if (regWrite)
                begin
                    if (keyIn == `KEY_SECOND)
                    begin
                        next_state             = BUSY_ST;         // [R9]
                        next_programFlashArray = 1'b1;
                        next_programSpace      =
                            sfrWrData[`SPACE_MSB:`SPACE_LSB];
                    end
                    else if (keyIn == `KEY_FIRST)
                        next_state = ARMED_ST;                    // [R12]
                    else
                        next_state = IDLE_ST;                     // [R12]
                end
            end
            BUSY_ST:
            begin
                // Keys written while busy are ignored
                if (timerDone)
                    next_state = IDLE_ST;                         // [R10]
            end
            default:
                next_state = IDLE_ST;
        endcase
        next_control.programInProgress =
            (next_state == BUSY_ST);                              // [R10]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            control           <= `FLASH_CONTROL_RESET;
            state             <= IDLE_ST;
            programFlashArray <= 1'b0;
            programSpace      <= `SPACE_USER;
        end
        else
        begin
            control           <= next_control;
            state             <= next_state;
            programFlashArray <= next_programFlashArray;
            programSpace      <= next_programSpace;
        end
    end

    // Busy timer, started by the launch pulse
    program_timer #(
        .CYCLES (PROGRAM_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (next_programFlashArray),
        .done    (timerDone)
    );

    // ------------------------------------------------------------
    // Register read, data space routing and code reads
    // ------------------------------------------------------------
    logic [7:0]      next_sfrRdData;
    latch_write_type next_latchWrite;
    logic            next_externalWrite;
    logic            next_arrayRead;
    logic [1:0]      next_arrayReadSpace;
    logic [15:0]     next_arrayReadAddr;
    logic            readPending;

    // True where a code address falls inside the selected space
    function automatic logic inSpace(input logic [1:0] sp,
                                     input logic [15:0] a);
        unique case (sp)
            `SPACE_USER:     inSpace = (a <= `USER_ADDR_MAX);
            `SPACE_EXTRA:    inSpace = (a >= `EXTRA_ADDR_MIN);
            `SPACE_SECURITY: inSpace = (a == `SECURITY_ADDR);
            default:         inSpace = 1'b0;
        endcase
    endfunction

    // Latch mapping wins over external data; reserved space reads 00h
    always_comb
    begin
        next_sfrRdData      = control;
        next_latchWrite     = '0;
        next_externalWrite  = 1'b0;
        next_arrayRead      = 1'b0;
        next_arrayReadSpace = arrayReadSpace;
        next_arrayReadAddr  = arrayReadAddr;
        if (dataWrite && control.latchMapSelect)                  // [R2] [R5]
        begin
            if (dataAddr <= `USER_ADDR_MAX)                       // [R3]
            begin
                next_latchWrite.valid   = 1'b1;
                next_latchWrite.byteSel =
                    dataAddr[`BYTE_MSB:0];                        // [R4]
                next_latchWrite.page    =
                    dataAddr[`PAGE_MSB:`PAGE_LSB];                // [R4]
                next_latchWrite.data    = dataWrData;
            end
        end
        else if (dataWrite && externalDataSelect)
            next_externalWrite = 1'b1;                            // [R1]
        if (codeRead && inSpace(control.spaceSelect, codeAddr))   // [R6] [R7]
        begin
            next_arrayRead      = 1'b1;
            next_arrayReadSpace = control.spaceSelect;
            next_arrayReadAddr  = codeAddr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sfrRdData      <= `FLASH_CONTROL_RESET;
            latchWrite     <= '0;
            externalWrite  <= 1'b0;
            arrayRead      <= 1'b0;
            arrayReadSpace <= `SPACE_USER;
            arrayReadAddr  <= '0;
            readPending    <= 1'b0;
            codeRdData     <= '0;
            codeRdValid    <= 1'b0;
        end
        else
        begin
            sfrRdData      <= next_sfrRdData;
            latchWrite     <= next_latchWrite;
            externalWrite  <= next_externalWrite;
            arrayRead      <= next_arrayRead;
            arrayReadSpace <= next_arrayReadSpace;
            arrayReadAddr  <= next_arrayReadAddr;
            readPending    <= codeRead;
            codeRdValid    <= readPending;                        // [R7]
            codeRdData     <= arrayRead ? arrayRdData : 8'h00;
        end
    end
endmodule // flash_space_map_and_program_launch

// >>> rtl/flash_map_consts.svh
// Constants for the flash space map and program launch block
`ifndef FLASH_MAP_CONSTS_SVH
`define FLASH_MAP_CONSTS_SVH
`define FLASH_CONTROL_ADDR   8'hd1
`define FLASH_CONTROL_RESET  8'h00
`define KEY_MSB              7
`define KEY_LSB              4
`define LATCH_MAP_BIT        3
`define SPACE_MSB            2
`define SPACE_LSB            1
`define BUSY_BIT             0
`define KEY_FIRST            4'h5
`define KEY_SECOND           4'ha
`define SPACE_USER           2'b00
`define SPACE_EXTRA          2'b01
`define SPACE_SECURITY       2'b10
`define USER_ADDR_MAX        16'h7fff
`define EXTRA_ADDR_MIN       16'hff80
`define SECURITY_ADDR        16'h0000
`define BYTE_MSB             6
`define PAGE_MSB             14
`define PAGE_LSB             7
`define PROGRAM_TIME_US      10
`define CLOCK_MHZ            10
`endif

// >>> rtl/flash_map_pkg.sv
// Types shared by the flash space map and program launch block
package flash_map_pkg;
    typedef enum logic [1:0]
    {
        IDLE_ST  = 2'b00,
        ARMED_ST = 2'b01,
        BUSY_ST  = 2'b11
    } launch_state_type;

    typedef struct packed
    {
        logic [3:0] launchKey;
        logic       latchMapSelect;
        logic [1:0] spaceSelect;
        logic       programInProgress;
    } flash_control_type;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] page;
        logic [6:0] byteSel;
        logic [7:0] data;
    } latch_write_type;
endpackage

// >>> rtl/program_timer.sv
// Busy-time counter for one flash programming operation
`include "flash_map_consts.svh"
module program_timer #(
    parameter int CYCLES = `PROGRAM_TIME_US * `CLOCK_MHZ
)(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_done;

    // Count down from the load value; done pulses as the count reaches zero
    always_comb
    begin
        next_count = count;
        next_done  = 1'b0;
        if (start)
            next_count = W'(CYCLES);
        else if (count != '0)
        begin
            next_count = count - W'(1);
            next_done  = (count == W'(1));
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            count <= '0;
            done  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            done  <= next_done;
        end
    end
endmodule // program_timer

// >>> testbench/flash_map_checker.sv
// Port-level checks for the flash map and launch block
module flash_map_checker
(
    // Clock and reset
    input wire logic                          ref_clk,
    input wire logic                          rst_n,
    // Register, data and code side
    input wire logic [7:0]                    sfrAddr,
    input wire logic                          sfrWrite,
    input wire logic [7:0]                    sfrWrData,
    input wire logic [7:0]                    sfrRdData,
    input wire logic                          dataWrite,
    input wire logic [15:0]                   dataAddr,
    input wire logic [7:0]                    dataWrData,
    input wire logic                          externalDataSelect,
    input wire logic                          externalWrite,
    input wire logic                          codeRead,
    input wire logic [15:0]                   codeAddr,
    input wire logic                          codeRdValid,
    // Array side
    input wire flash_map_pkg::latch_write_type latchWrite,
    input wire logic                          arrayRead,
    input wire logic [15:0]                   arrayReadAddr,
    input wire logic                          programFlashArray,
    input wire logic [1:0]                    programSpace
);
    timeunit 1ns;
    timeprecision 1ns;
    import flash_map_pkg::*;
    logic       mapOn;
    logic [1:0] spc;
    logic       regHit;
    assign regHit = sfrWrite && sfrAddr == 8'hd1;
    // Shadow of the map bits, since the register itself is hidden
    always_ff @(posedge ref_clk)
        if (!rst_n)
            {mapOn, spc} <= 3'h0;
        else if (regHit)
            {mapOn, spc} <= sfrWrData[3:1];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Readback shows busy one edge late; the launch pulse covers the gap
    sequence keyOne;
        regHit && sfrWrData[7:4] == 4'h5 && !sfrRdData[0]
            && !programFlashArray;
    endsequence
    sequence keyTwo;
        regHit && sfrWrData[7:4] == 4'ha;
    endsequence
    a_launch_pair: assert property (keyOne ##1 keyTwo |=>
        programFlashArray)
        else $error("launch missing");
    a_launch_cause: assert property (programFlashArray |->
        $past(regHit) && $past(sfrWrData[7:4]) == 4'ha)
        else $error("launch without key");
    a_space_copy: assert property (programFlashArray |->
        programSpace == $past(sfrWrData[2:1]))
        else $error("wrong space launched");
    a_busy_shown: assert property (programFlashArray |=>
        sfrRdData[0])
        else $error("busy not shown");
    a_reg_readback: assert property (regHit ##1 !regHit |=>
        sfrRdData[7:1] == $past(sfrWrData[7:1], 2))
        else $error("register readback");
    a_latch_addr: assert property (
        dataWrite && mapOn && !dataAddr[15] |=> latchWrite.valid
        && latchWrite.page == $past(dataAddr[14:7])
        && latchWrite.byteSel == $past(dataAddr[6:0])
        && latchWrite.data == $past(dataWrData))
        else $error("latch write wrong");
    a_latch_first: assert property (dataWrite && mapOn |=>
        !externalWrite)
        else $error("external write while mapped");
    a_ext_route: assert property (
        dataWrite && !mapOn && externalDataSelect |=>
        externalWrite && !latchWrite.valid)
        else $error("unmapped write routing");
    a_array_fetch: assert property (
        codeRead && spc == 2'b00 && !codeAddr[15] |=>
        arrayRead && arrayReadAddr == $past(codeAddr))
        else $error("array fetch wrong");
    a_read_answer: assert property (codeRead |-> ##2 codeRdValid)
        else $error("code read unanswered");
    a_space_reserved: assert property (
        codeRead && spc == 2'b11 |=> !arrayRead)
        else $error("reserved space read");
endmodule // flash_map_checker
bind flash_space_map_and_program_launch flash_map_checker checker_i (
    .ref_clk, .rst_n, .sfrAddr, .sfrWrite, .sfrWrData, .sfrRdData,
    .dataWrite, .dataAddr, .dataWrData, .externalDataSelect,
    .externalWrite, .codeRead, .codeAddr, .codeRdValid, .latchWrite,
    .arrayRead, .arrayReadAddr, .programFlashArray, .programSpace
);

// >>> testbench/flash_array_model.sv
// Behavioural flash array answering the block's read strobe
module flash_array_model
(
    // Read request
    input  wire logic        arrayRead,
    input  wire logic [1:0]  arrayReadSpace,
    input  wire logic [15:0] arrayReadAddr,
    // Read data
    output logic      [7:0]  arrayRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    // Inverted when not read, so stale data is never mistaken for an answer
    always_comb
        arrayRdData = {8{arrayRead}}
            ~^ (arrayReadAddr[7:0] ^ {arrayReadSpace, 6'h15});
endmodule // flash_array_model

// >>> testbench/tb_top.sv
// Self-checking bench for the flash map and launch block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_map_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, dataWrite = 1'b0;
    logic codeRead = 1'b0, externalDataSelect = 1'b0;
    logic [7:0] sfrAddr = 8'hd1, sfrWrData = 8'h00, dataWrData = 8'h00;
    logic [15:0] dataAddr = 16'h0000, codeAddr = 16'h0000, arrayReadAddr;
    logic [7:0] sfrRdData, codeRdData, arrayRdData;
    logic externalWrite, codeRdValid, arrayRead, programFlashArray;
    logic [1:0] arrayReadSpace, programSpace;
    latch_write_type latchWrite;
    int n_mismatch = 0, cmp_count = 0, nLaunch = 0;
    localparam logic [15:0] RA [6] = '{16'h1234, 16'h8000, 16'hff85,
                                       16'h0010, 16'h0000, 16'h0000};
    localparam logic [1:0] RS [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    localparam logic [5:0] INSIDE = 6'h15;

    // Short busy time keeps the run brief
    flash_space_map_and_program_launch #(
        .PROGRAM_CYCLES (3)
    ) flash_space_map_and_program_launch_i (
        .ref_clk, .rst_n, .sfrAddr, .sfrWrite, .sfrWrData, .sfrRdData,
        .dataWrite, .dataAddr, .dataWrData, .externalDataSelect,
        .externalWrite, .codeRead, .codeAddr, .codeRdData, .codeRdValid,
        .latchWrite, .arrayReadSpace, .arrayReadAddr, .arrayRead,
        .arrayRdData, .programFlashArray, .programSpace
    );
    flash_array_model flash_array_model_i (
        .arrayRead, .arrayReadSpace, .arrayReadAddr, .arrayRdData
    );

    initial
        forever #50 ref_clk = ~ref_clk;
    // Launch pulses counted to catch spurious starts
    always @(posedge ref_clk)
        if (programFlashArray === 1'b1)
            nLaunch <= nLaunch + 1;

    // Wide enough for the whole latch word plus a flag beside it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge ref_clk);
        sfrWrite <= 1'b1;
        sfrWrData <= d;
    endtask
    task automatic dw(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        dataWrite <= 1'b1;
        dataAddr <= a;
        dataWrData <= d;
    endtask
    // Drops every strobe; the #1 lets that edge's updates settle
    task automatic idle;
        @(posedge ref_clk);
        sfrWrite <= 1'b0;
        dataWrite <= 1'b0;
        codeRead <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        check(sfrRdData, exp);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        int i;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h00);
        wr(8'h0f);
        idle;
        rd(8'h0e);
        $display("test register done");
        for (i = 0; i < 6; i++)
        begin
            wr({5'h00, RS[i], 1'b0});
            idle;
            @(posedge ref_clk);
            codeRead <= 1'b1;
            codeAddr <= RA[i];
            idle;
            rd(8'h00 | {RS[i], 1'b0});
            check({codeRdValid, codeRdData},
                {1'b1, INSIDE[i] ? RA[i][7:0] ^ {RS[i], 6'h15} : 8'h00});
        end
        $display("test code read done");
        wr(8'h08);
        externalDataSelect <= 1'b1;
        idle;
        dw(16'h7fff, 8'h5a);
        idle;
        check({latchWrite, externalWrite},
              {1'b1, 8'hff, 7'h7f, 8'h5a, 1'b0});
        dw(16'h0081, 8'hc3);
        idle;
        check(latchWrite, {1'b1, 8'h01, 7'h01, 8'hc3});
        dw(16'h8000, 8'h33);
        idle;
        check({latchWrite.valid, externalWrite}, 2'b00);
        wr(8'h00);
        idle;
        dw(16'h0100, 8'h11);
        idle;
        check({latchWrite.valid, externalWrite}, 2'b01);
        $display("test latch done");
        wr(8'h50);
        wr(8'ha4);
        idle;
        check({programFlashArray, programSpace}, 3'b110);
        rd(8'ha5);
        // The read that sees busy drop is still a valid step; mask bit 0
        for (i = 0; i < 20 && sfrRdData[0] !== 1'b0; i++)
        begin
            @(posedge ref_clk);
            #1;
            check(sfrRdData | 8'h01, 8'ha5);
        end
        if (i == 20)
        begin
            n_mismatch++;
            tally_and_finish;
        end
        check(sfrRdData, 8'ha4);
        wr(8'h50);
        wr(8'h34);
        wr(8'ha4);
        idle;
        rd(8'ha4);
        check(nLaunch, 1);
        wr(8'h50);
        wr(8'ha2);
        idle;
        check({programFlashArray, programSpace}, 3'b101);
        $display("test launch done");
        tally_and_finish;
    end
endmodule // tb_top
